// ===== rtl/cpu_status_flag_logic.sv
// status flag register of the core with event interrupt and register port
// Operation
// - subtract: chained zero equals zero flag
// - watchdog time-out sets expiry flag
// - power-up, refresh or halt clear expiry
// - halt instruction sets halted flag
// - power-up or refresh clear halted flag
// - wrap flag: carry into msb xor out
// - zero flag set on null add, subtract or logic result, kept on rotate
// - signed compare is wrap xor msb
// - half carry from low nibble, no-borrow
// - carry on carry/no-borrow, also rotates
// - software writes never change expiry/halted
//
// Chosen here: the register offsets and strobed register access.
`include "csf_params.svh"

module cpu_status_flag_logic (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire csf_pkg::csf_alu_t ALU,
  input wire csf_pkg::csf_sys_t SYS,
  input wire csf_pkg::csf_bus_t BUS,
  output logic [7:0] RDATA,
  output csf_pkg::csf_flags_t FLAGS,
  output logic IRQ
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  csf_pkg::csf_flags_t flags_ff;
  csf_pkg::csf_flags_t nxt_flags;
  csf_pkg::csf_flags_t arith_flags;
  logic [2:0] evt_sts_ff;
  logic [2:0] nxt_evt_sts;
  logic [2:0] evt_mask_ff;
  logic [2:0] nxt_evt_mask;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;
  logic sys_expiry;
  logic sys_halted;
  logic wr_flags;
  logic wr_sts;
  logic wr_mask;
  logic [2:0] evt;

  // ----------------------------------------
  // flag computation
  // ----------------------------------------
  csf_arith_flags u_arith (
    .cur(flags_ff),
    .alu(ALU),
    .nxt(arith_flags)
  );

  csf_sys_flags u_sys (
    .cur_expiry(flags_ff.watchdog_expiry_flag),
    .cur_halted(flags_ff.halted_flag),
    .sys(SYS),
    .nxt_expiry(sys_expiry),
    .nxt_halted(sys_halted)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    wr_flags = BUS.wr && (BUS.addr == `CSF_ADDR_FLAGS);
    wr_sts = BUS.wr && (BUS.addr == `CSF_ADDR_EVT_STS);
    wr_mask = BUS.wr && (BUS.addr == `CSF_ADDR_EVT_MASK);
    nxt_flags = arith_flags;
    nxt_flags.watchdog_expiry_flag = sys_expiry;
    nxt_flags.halted_flag = sys_halted;
    if (wr_flags) begin
      nxt_flags = csf_pkg::csf_flags_t'((nxt_flags & ~`CSF_FLAGS_SW_MASK) | (BUS.wdata & `CSF_FLAGS_SW_MASK));
    end
    evt = 3'h0;
    evt[`CSF_EVT_WDT] = SYS.timeout;
    evt[`CSF_EVT_HALT] = SYS.halt;
    evt[`CSF_EVT_WRAP] = arith_flags.arith_wrap_flag && (ALU.op != csf_pkg::CSF_OP_NONE) &&
                         (ALU.op != csf_pkg::CSF_OP_LOGIC) && (ALU.op != csf_pkg::CSF_OP_ROT);
    // new events win over a same-cycle clear
    nxt_evt_sts = (evt_sts_ff & ~(wr_sts ? BUS.wdata[2:0] : 3'h0)) | evt;
    nxt_evt_mask = wr_mask ? BUS.wdata[2:0] : evt_mask_ff;
    // irq follows next values so it stays a plain flop
    nxt_irq = |(nxt_evt_sts & nxt_evt_mask);
    nxt_rdata = 8'h00;
    if (BUS.rd) begin
      unique case (BUS.addr)
        `CSF_ADDR_FLAGS: nxt_rdata = flags_ff;
        `CSF_ADDR_EVT_STS: nxt_rdata = {5'h00, evt_sts_ff};
        `CSF_ADDR_EVT_MASK: nxt_rdata = {5'h00, evt_mask_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      flags_ff <= `CSF_FLAGS_RESET;
      evt_sts_ff <= `CSF_EVT_RESET;
      evt_mask_ff <= `CSF_MASK_RESET;
      rdata_ff <= 8'h00;
      irq_ff <= 1'b0;
    end else if (CE) begin
      flags_ff <= nxt_flags;
      evt_sts_ff <= nxt_evt_sts;
      evt_mask_ff <= nxt_evt_mask;
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
    end
  end

  assign FLAGS = flags_ff;
  assign RDATA = rdata_ff;
  assign IRQ = irq_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  logic is_arith_op;
  assign is_arith_op = (ALU.op == csf_pkg::CSF_OP_ADD) || (ALU.op == csf_pkg::CSF_OP_SUB) ||
                       (ALU.op == csf_pkg::CSF_OP_SBC);

  property p_cz_sub;
    CE && ALU.op == csf_pkg::CSF_OP_SUB |=> FLAGS.chained_zero_flag == FLAGS.zero_flag;
  endproperty
  a_cz_sub: assert property (p_cz_sub) else $error("chained zero differs after subtract");

  property p_cz_sbc;
    CE && ALU.op == csf_pkg::CSF_OP_SBC |=>
      FLAGS.chained_zero_flag == ($past(FLAGS.chained_zero_flag) && $past(ALU.result) == 8'h00);
  endproperty
  a_cz_sbc: assert property (p_cz_sbc) else $error("chained zero wrong after borrow subtract");

  property p_cz_keep;
    (!CE || (ALU.op != csf_pkg::CSF_OP_SUB && ALU.op != csf_pkg::CSF_OP_SBC)) |=> $stable(FLAGS.chained_zero_flag);
  endproperty
  a_cz_keep: assert property (p_cz_keep) else $error("chained zero changed by other instruction");

  property p_to_set;
    CE && SYS.timeout |=> FLAGS.watchdog_expiry_flag;
  endproperty
  a_to_set: assert property (p_to_set) else $error("expiry flag not set on time-out");

  property p_to_clr;
    CE && !SYS.timeout && (SYS.refresh || SYS.halt) |=> !FLAGS.watchdog_expiry_flag;
  endproperty
  a_to_clr: assert property (p_to_clr) else $error("expiry flag not cleared");

  property p_pd_set;
    CE && SYS.halt |=> FLAGS.halted_flag && IRQ == |(evt_sts_ff & evt_mask_ff);
  endproperty
  a_pd_set: assert property (p_pd_set) else $error("halted flag not set on halt");

  sequence s_halt_step;
    CE && SYS.halt && !SYS.refresh && !SYS.timeout;
  endsequence
  sequence s_refresh_step;
    CE && SYS.refresh && !SYS.halt && !SYS.timeout;
  endsequence
  property p_pd_clr;
    s_halt_step ##1 s_refresh_step |=> !FLAGS.halted_flag && !FLAGS.watchdog_expiry_flag;
  endproperty
  a_pd_clr: assert property (p_pd_clr) else $error("refresh after halt left system flags set");

  property p_wrap;
    CE && is_arith_op && !wr_flags |=>
      FLAGS.arith_wrap_flag == ($past(ALU.carry_msb) ^ $past(ALU.carry_out));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag wrong");

  property p_zero;
    CE && (is_arith_op || ALU.op == csf_pkg::CSF_OP_LOGIC) && !wr_flags |=>
      FLAGS.zero_flag == ($past(ALU.result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sc;
    CE && is_arith_op |=> FLAGS.signed_compare_flag == (FLAGS.arith_wrap_flag ^ $past(ALU.result[7]))
      || $past(wr_flags);
  endproperty
  a_sc: assert property (p_sc) else $error("signed compare flag wrong");

  property p_half;
    CE && is_arith_op && !wr_flags |=> FLAGS.half_carry_flag == $past(ALU.carry_nib);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");

  property p_carry;
    CE && (is_arith_op || ALU.op == csf_pkg::CSF_OP_ROT) && !wr_flags |=> FLAGS.carry_flag == $past(ALU.carry_out);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");

  property p_sw_sys;
    CE && wr_flags && !SYS.timeout && !SYS.refresh && !SYS.halt |=>
      $stable(FLAGS.watchdog_expiry_flag) && $stable(FLAGS.halted_flag);
  endproperty
  a_sw_sys: assert property (p_sw_sys) else $error("software write changed system flags");

  property p_rd_once;
    CE && !BUS.rd |=> RDATA == 8'h00;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read data stands without a read");

  property p_evt_wdt;
    CE && SYS.timeout |=> evt_sts_ff[`CSF_EVT_WDT];
  endproperty
  a_evt_wdt: assert property (p_evt_wdt) else $error("time-out event not latched");

  property p_evt_halt;
    CE && SYS.halt |=> evt_sts_ff[`CSF_EVT_HALT];
  endproperty
  a_evt_halt: assert property (p_evt_halt) else $error("halt event not latched");

  property p_evt_wrap;
    CE && is_arith_op && (ALU.carry_msb ^ ALU.carry_out) |=> evt_sts_ff[`CSF_EVT_WRAP];
  endproperty
  a_evt_wrap: assert property (p_evt_wrap) else $error("wrap event not latched");

  property p_rd_flags;
    CE && BUS.rd && BUS.addr == `CSF_ADDR_FLAGS |=> RDATA == $past(FLAGS);
  endproperty
  a_rd_flags: assert property (p_rd_flags) else $error("flag read data wrong");

  // status read returns latched events
  property p_rd_sts;
    CE && BUS.rd && BUS.addr == `CSF_ADDR_EVT_STS |=> RDATA == {5'h00, $past(evt_sts_ff)};
  endproperty
  a_rd_sts: assert property (p_rd_sts) else $error("status read data wrong");

  // mask write lands next cycle
  property p_mask_wr;
    CE && wr_mask |=> evt_mask_ff == $past(BUS.wdata[2:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");

  property p_sw_low;
    CE && wr_flags |=> {FLAGS.arith_wrap_flag, FLAGS.zero_flag, FLAGS.half_carry_flag, FLAGS.carry_flag} ==
      $past(BUS.wdata[3:0]);
  endproperty
  a_sw_low: assert property (p_sw_low) else $error("software flag write lost");

  property p_logic_keep;
    CE && ALU.op == csf_pkg::CSF_OP_LOGIC && !wr_flags |=>
      $stable(FLAGS.carry_flag) && $stable(FLAGS.half_carry_flag) && $stable(FLAGS.arith_wrap_flag);
  endproperty
  a_logic_keep: assert property (p_logic_keep) else $error("logic op touched carry flags");

  property p_rot_keep;
    CE && ALU.op == csf_pkg::CSF_OP_ROT && !wr_flags |=> $stable(FLAGS.zero_flag) && $stable(FLAGS.arith_wrap_flag);
  endproperty
  a_rot_keep: assert property (p_rot_keep) else $error("rotate touched zero or wrap");

  // system flags move only on events
  property p_sys_hold;
    CE && !SYS.timeout && !SYS.refresh && !SYS.halt |=>
      $stable(FLAGS.watchdog_expiry_flag) && $stable(FLAGS.halted_flag);
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("system flags moved without event");

  // frozen core holds every output
  property p_frozen;
    !CE |=> $stable(FLAGS) && $stable(IRQ) && $stable(RDATA);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state changed with enable low");

  // interrupt tracks unmasked status
  property p_irq;
    CE |=> IRQ == |(evt_sts_ff & evt_mask_ff);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule

// ===== rtl/csf_arith_flags.sv
// next values of the arithmetic condition flags for one executed instruction
module csf_arith_flags (
  input wire csf_pkg::csf_flags_t cur,
  input wire csf_pkg::csf_alu_t alu,
  output csf_pkg::csf_flags_t nxt
);

  logic is_arith;
  logic res_zero;
  logic wrap;

  always_comb begin
    is_arith = (alu.op == csf_pkg::CSF_OP_ADD) || (alu.op == csf_pkg::CSF_OP_SUB) ||
               (alu.op == csf_pkg::CSF_OP_SBC);
    res_zero = (alu.result == 8'h00);
    wrap = alu.carry_msb ^ alu.carry_out;
    nxt = cur;
    if (is_arith) begin
      nxt.arith_wrap_flag = wrap;
      nxt.signed_compare_flag = wrap ^ alu.result[7];
      nxt.half_carry_flag = alu.carry_nib;
      nxt.carry_flag = alu.carry_out;
    end
    if (is_arith || alu.op == csf_pkg::CSF_OP_LOGIC) begin
      nxt.zero_flag = res_zero;
    end
    if (alu.op == csf_pkg::CSF_OP_ROT) begin
      nxt.carry_flag = alu.carry_out;
    end
    if (alu.op == csf_pkg::CSF_OP_SUB) begin
      nxt.chained_zero_flag = res_zero;
    end
    if (alu.op == csf_pkg::CSF_OP_SBC) begin
      nxt.chained_zero_flag = cur.chained_zero_flag & res_zero;
    end
  end

endmodule

// ===== rtl/csf_params.svh
// offsets, field positions, reset values and masks of the status flag block
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CSF_ADDR_FLAGS 2'h0
`define CSF_ADDR_EVT_STS 2'h1
`define CSF_ADDR_EVT_MASK 2'h2

// ----------------------------------------
// flag register fields
// ----------------------------------------
`define CSF_BIT_SIGNED_CMP 7
`define CSF_BIT_CHAINED_ZERO 6
`define CSF_BIT_WDT_EXPIRY 5
`define CSF_BIT_HALTED 4
`define CSF_BIT_WRAP 3
`define CSF_BIT_ZERO 2
`define CSF_BIT_HALF_CARRY 1
`define CSF_BIT_CARRY 0
`define CSF_FLAGS_SW_MASK 8'h0F
`define CSF_FLAGS_RESET 8'h00

// ----------------------------------------
// event status / mask fields
// ----------------------------------------
`define CSF_EVT_WDT 0
`define CSF_EVT_HALT 1
`define CSF_EVT_WRAP 2
`define CSF_EVT_RESET 3'h0
`define CSF_MASK_RESET 3'h0

`endif

// ===== rtl/csf_pkg.sv
// types shared by the status flag block
package csf_pkg;

  typedef enum logic [5:0] {
    CSF_OP_NONE  = 6'h01,
    CSF_OP_ADD   = 6'h02,
    CSF_OP_SUB   = 6'h04,
    CSF_OP_SBC   = 6'h08,
    CSF_OP_LOGIC = 6'h10,
    CSF_OP_ROT   = 6'h20
  } csf_op_t;

  typedef struct packed {
    csf_op_t op;
    logic [7:0] result;
    logic carry_out;
    logic carry_msb;
    logic carry_nib;
  } csf_alu_t;

  typedef struct packed {
    logic signed_compare_flag;
    logic chained_zero_flag;
    logic watchdog_expiry_flag;
    logic halted_flag;
    logic arith_wrap_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
  } csf_flags_t;

  typedef struct packed {
    logic timeout;
    logic refresh;
    logic halt;
  } csf_sys_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } csf_bus_t;

endpackage

// ===== rtl/csf_sys_flags.sv
// next values of the watchdog expiry and halted flags
module csf_sys_flags (
  input wire logic cur_expiry,
  input wire logic cur_halted,
  input wire csf_pkg::csf_sys_t sys,
  output logic nxt_expiry,
  output logic nxt_halted
);

  always_comb begin
    nxt_expiry = cur_expiry;
    nxt_halted = cur_halted;
    if (sys.refresh || sys.halt) begin
      nxt_expiry = 1'b0;
    end
    if (sys.timeout) begin
      nxt_expiry = 1'b1;
    end
    if (sys.refresh) begin
      nxt_halted = 1'b0;
    end
    if (sys.halt) begin
      nxt_halted = 1'b1;
    end
  end

endmodule

// ===== sim/cpu_status_flag_logic_test.sv
// self-checking bench of the status flag block
module cpu_status_flag_logic_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic CE = 1'b1;
  csf_pkg::csf_alu_t ALU = '0;
  csf_pkg::csf_sys_t SYS = '0;
  csf_pkg::csf_bus_t BUS = '0;
  logic [7:0] RDATA;
  csf_pkg::csf_flags_t FLAGS;
  logic IRQ;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_cyc = 0;

  cpu_status_flag_logic dut_u (
    .MCLK(MCLK),
    .RST(RST),
    .CE(CE),
    .ALU(ALU),
    .SYS(SYS),
    .BUS(BUS),
    .RDATA(RDATA),
    .FLAGS(FLAGS),
    .IRQ(IRQ)
  );

  always #2.5 MCLK = ~MCLK;

  // run needs about 90 cycles; ceiling well above
  always @(posedge MCLK) begin
    n_cyc++;
    if (n_cyc == 3000) begin
      n_mismatch++;
      $display("Error at %0t: run did not finish", $time);
      stop_test();
    end
  end

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // c is {carry_out, carry_msb, carry_nib}
  task automatic alu(input csf_pkg::csf_op_t op, input logic [7:0] res, input logic [2:0] c,
                     input logic [7:0] exp);
    @(posedge MCLK);
    ALU <= '{op, res, c[2], c[1], c[0]};
    @(posedge MCLK);
    ALU.op <= csf_pkg::CSF_OP_NONE;
    #1;
    chk(FLAGS, exp);
  endtask

  // p is {timeout, refresh, halt}; only expiry and halted compared
  task automatic sysp(input logic [2:0] p, input logic [7:0] exp);
    @(posedge MCLK);
    SYS <= p;
    @(posedge MCLK);
    SYS <= 3'h0;
    #1;
    chk(FLAGS & 8'h30, exp);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge MCLK);
    BUS <= '{a, d, 1'b1, 1'b0};
    @(posedge MCLK);
    BUS.wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge MCLK);
    BUS <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge MCLK);
    BUS.rd <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask

  task automatic irq_chk(input logic e);
    @(posedge MCLK);
    #1;
    chk({7'h00, IRQ}, {7'h00, e});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge MCLK);
    RST <= 1'b0;
    #1;
    chk(FLAGS, 8'h00);
    rd(2'h0, 8'h00);
    alu(csf_pkg::CSF_OP_ADD, 8'h80, 3'b011, 8'h0A);
    alu(csf_pkg::CSF_OP_ADD, 8'h80, 3'b000, 8'h80);
    alu(csf_pkg::CSF_OP_ADD, 8'h00, 3'b100, 8'h8D);
    alu(csf_pkg::CSF_OP_SUB, 8'h00, 3'b111, 8'h47);
    alu(csf_pkg::CSF_OP_SBC, 8'h00, 3'b111, 8'h47);
    alu(csf_pkg::CSF_OP_SBC, 8'h05, 3'b110, 8'h01);
    alu(csf_pkg::CSF_OP_SBC, 8'h00, 3'b111, 8'h07);
    alu(csf_pkg::CSF_OP_SUB, 8'h00, 3'b111, 8'h47);
    alu(csf_pkg::CSF_OP_LOGIC, 8'h90, 3'b000, 8'h43);
    alu(csf_pkg::CSF_OP_ROT, 8'h00, 3'b000, 8'h42);
    alu(csf_pkg::CSF_OP_ROT, 8'h00, 3'b100, 8'h43);
    @(posedge MCLK);
    CE <= 1'b0;
    // frozen core must not take the instruction
    alu(csf_pkg::CSF_OP_ADD, 8'h00, 3'b111, 8'h43);
    @(posedge MCLK);
    CE <= 1'b1;
    $display("test arith done");
    sysp(3'b100, 8'h20);
    sysp(3'b001, 8'h10);
    sysp(3'b100, 8'h30);
    sysp(3'b010, 8'h00);
    sysp(3'b001, 8'h10);
    @(posedge MCLK);
    SYS <= 3'b001;
    @(posedge MCLK);
    SYS <= 3'b010;
    @(posedge MCLK);
    SYS <= 3'h0;
    #1;
    chk(FLAGS & 8'h30, 8'h00);
    sysp(3'b001, 8'h10);
    $display("test system flags done");
    wr(2'h0, 8'hA0);
    chk(FLAGS, 8'h50);
    wr(2'h0, 8'hEF);
    rd(2'h0, 8'h5F);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    rd(2'h0, 8'h5F);
    $display("test register done");
    rd(2'h1, 8'h07);
    irq_chk(1'b0);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'h07);
    irq_chk(1'b1);
    wr(2'h1, 8'h07);
    rd(2'h1, 8'h00);
    irq_chk(1'b0);
    wr(2'h2, 8'h04);
    sysp(3'b100, 8'h30);
    irq_chk(1'b0);
    alu(csf_pkg::CSF_OP_ADD, 8'h80, 3'b011, 8'h7A);
    irq_chk(1'b1);
    wr(2'h1, 8'h04);
    irq_chk(1'b0);
    rd(2'h1, 8'h01);
    $display("test interrupt done");
    stop_test();
  end
endmodule
